/* rtl/pcg_top.sv */
// Contract
// (RL1) Gate bit one clocks unit, zero stops it
// (RL2) Access to unclocked unit answers bus fault
// (RL3) All gate bits reset to zero
// (RL4) Software alone enables needed units
// (RL5) Run, sleep, deep registers follow power state
// (RL6) Sleep registers apply only with auto gating
// (RL7) Sleep gate register at 0x114, resets zero
// (RL8) Bits 19..16 gate counters three to zero
// (RL9) Bit 12 gates two-wire unit zero
// (RL10) Bits 5 and 4 gate sync serial units
// (RL11) Bit 0 gates async serial unit zero
// (RL12) Reserved bits read zero, ignore writes
// (RL13) Software preserves reserved bits on update
// (RL14) Run gate register at 0x104, same layout
// (RL15) Gates switch only while clock is low
`timescale 1ns/1ns
`default_nettype none
`include "pcg_params.svh"
module pcg_top (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [11:0] I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  output logic             O_WB_ERR,
  input  wire logic [1:0]  I_PWR_STATE,
  input  wire logic        I_PERIPH_REQ,
  input  wire logic [7:0]  I_PERIPH_SEL,
  output logic             O_PERIPH_FAULT,
  output logic             O_PERIPH_GRANT,
  output logic      [7:0]  O_PERIPH_EN,
  output logic      [7:0]  O_PERIPH_CLK,
  output logic             O_IRQ
);

  // ************************************************************
  // Helper functions.
  // ************************************************************

  // Collects the eight gate fields of a gating register into
  // one vector: counters 3..0, two-wire, sync 1, sync 0, async.
  function automatic logic [7:0] units_of(input logic [31:0] r);
    units_of = {r[`PCG_GPC3_BIT], r[`PCG_GPC2_BIT], // RL8
                r[`PCG_GPC1_BIT], r[`PCG_GPC0_BIT],
                r[`PCG_TWU0_BIT],                   // RL9
                r[`PCG_SSU1_BIT], r[`PCG_SSU0_BIT], // RL10
                r[`PCG_ASU0_BIT]};                  // RL11
  endfunction : units_of

  // Byte-lane merge of write data, limited to writable bits.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel,
                                        input logic [31:0] wm);
    logic [31:0] lane;
    lane  = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = ((old & ~lane) | (dat & lane)) & wm;
  endfunction : merge

  // True when the word address selects the given offset.
  function automatic logic at(input logic [11:0] adr,
                              input logic [11:0] ofs);
    at = (adr[11:2] == ofs[11:2]);
  endfunction : at

  // ************************************************************
  // Declarations.
  // ************************************************************
  logic [31:0] run_gate_ff;     // Run-state gating register.
  logic [31:0] slp_gate_ff;     // Sleep-state gating register.
  logic [31:0] dsl_gate_ff;     // Deep-sleep gating register.
  logic [31:0] cfg_ff;          // Holds the auto gating select.
  logic [31:0] ist_ff;          // Sticky interrupt status.
  logic [31:0] imsk_ff;         // Interrupt mask.
  logic [7:0]  en_ff;           // Effective per-unit enables.
  logic [7:0]  nxt_en;          // Next effective enables.
  logic [1:0]  pwr_q_ff;        // Power state seen last cycle.
  logic        ack_ff;          // Registered acknowledge.
  logic        err_ff;          // Registered error answer.
  logic [31:0] rdat_ff;         // Registered read data.
  logic        req;             // New bus request this cycle.
  logic        mapped;          // Address hits a register.
  logic        wr;              // Write accepted this cycle.
  logic [31:0] ev;              // Event pulses for the status.
  logic [31:0] clr;             // Write-one-to-clear pattern.
  logic        fault;           // Fault pulse from the checker.
  logic        auto_gate;       // Auto gating select bit.
  pcg_pkg::pcg_pwr_t pwr;       // Decoded power state.

  // ************************************************************
  // Bus decode.
  // ************************************************************

  // A request counts once: in the cycle of its answer it is idle.
  assign req = I_WB_CYC & I_WB_STB & ~ack_ff & ~err_ff;

  // Only the six word offsets below are mapped.
  assign mapped = at(I_WB_ADR, `PCG_RUN_OFS)
                | at(I_WB_ADR, `PCG_SLP_OFS)
                | at(I_WB_ADR, `PCG_DSL_OFS)
                | at(I_WB_ADR, `PCG_CFG_OFS)
                | at(I_WB_ADR, `PCG_IST_OFS)
                | at(I_WB_ADR, `PCG_IMSK_OFS);

  assign wr = req & mapped & I_WB_WE;

  // Answer one cycle after the request; unmapped gets an error.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= req & mapped;
      err_ff <= req & ~mapped;
    end
  end

  assign O_WB_ACK = ack_ff;
  assign O_WB_ERR = err_ff;

  // ************************************************************
  // Gating registers.
  // ************************************************************

  // Only software sets gate bits; nothing here sets them itself.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      run_gate_ff <= `PCG_GATE_RST; // RL3
      slp_gate_ff <= `PCG_GATE_RST; // RL3
      dsl_gate_ff <= `PCG_GATE_RST; // RL3
    end else if (wr) begin
      // Writable mask keeps the reserved bits at zero.
      if (at(I_WB_ADR, `PCG_RUN_OFS)) begin
        run_gate_ff <= merge(run_gate_ff, I_WB_DAT, I_WB_SEL,
                             `PCG_GATE_WMASK); // RL14 RL12
      end
      if (at(I_WB_ADR, `PCG_SLP_OFS)) begin
        slp_gate_ff <= merge(slp_gate_ff, I_WB_DAT, I_WB_SEL,
                             `PCG_GATE_WMASK); // RL7 RL12
      end
      if (at(I_WB_ADR, `PCG_DSL_OFS)) begin
        dsl_gate_ff <= merge(dsl_gate_ff, I_WB_DAT, I_WB_SEL,
                             `PCG_GATE_WMASK); // RL12
      end
    end
  end

  // Clock configuration: only the auto gating select exists.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_ff <= `PCG_CFG_RST;
    end else if (wr && at(I_WB_ADR, `PCG_CFG_OFS)) begin
      cfg_ff <= merge(cfg_ff, I_WB_DAT, I_WB_SEL, `PCG_CFG_WMASK);
    end
  end

  assign auto_gate = cfg_ff[`PCG_ACG_BIT];

  // ************************************************************
  // Power state selection.
  // ************************************************************
  assign pwr = pcg_pkg::pcg_pwr_t'(I_PWR_STATE);

  // Without auto gating the run settings stay in force in every
  // state, so software that never sets it sees no surprises.
  always_comb begin
    unique case (pwr)
      pcg_pkg::PCG_RUN: begin
        nxt_en = units_of(run_gate_ff); // RL5
      end
      pcg_pkg::PCG_SLEEP: begin
        nxt_en = auto_gate ? units_of(slp_gate_ff) // RL6
                           : units_of(run_gate_ff);
      end
      pcg_pkg::PCG_DEEP: begin
        nxt_en = auto_gate ? units_of(dsl_gate_ff) // RL5
                           : units_of(run_gate_ff);
      end
      default: begin
        // Unused code: fall back to the run settings.
        nxt_en = units_of(run_gate_ff);
      end
    endcase
  end

  // Registered so the gates see a clean, glitch-free level.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      en_ff    <= 8'h00; // RL3
      pwr_q_ff <= 2'h0;
    end else begin
      en_ff    <= nxt_en;
      pwr_q_ff <= I_PWR_STATE;
    end
  end

  assign O_PERIPH_EN = en_ff;

  // ************************************************************
  // Clock gates and access checker.
  // ************************************************************
  for (genvar g = 0; g < 8; g++) begin : g_gate
    pcg_clk_gate u_gate (
      .i_clk  (I_MCLK),
      .i_rst  (I_RST),
      .i_en   (en_ff[g]),         // RL1
      .o_gclk (O_PERIPH_CLK[g])
    );
  end

  pcg_fault_chk u_chk (
    .i_clk   (I_MCLK),
    .i_rst   (I_RST),
    .i_req   (I_PERIPH_REQ),
    .i_sel   (I_PERIPH_SEL),
    .i_en    (en_ff),             // RL2
    .o_fault (fault),
    .o_grant (O_PERIPH_GRANT)
  );

  assign O_PERIPH_FAULT = fault;

  // ************************************************************
  // Interrupts.
  // ************************************************************
  always_comb begin
    ev = 32'h00000000;
    ev[`PCG_EV_FAULT] = fault;
    ev[`PCG_EV_PWR]   = (pwr_q_ff != I_PWR_STATE);
  end

  assign clr = (wr && at(I_WB_ADR, `PCG_IST_OFS))
             ? merge(32'h00000000, I_WB_DAT, I_WB_SEL, `PCG_IRQ_WMASK)
             : 32'h00000000;

  // Set wins over clear so no event is lost on a clear write.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ist_ff <= `PCG_IRQ_RST;
    end else begin
      ist_ff <= ((ist_ff & ~clr) | ev) & `PCG_IRQ_WMASK;
    end
  end

  // Mask register, same layout as the status.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      imsk_ff <= `PCG_IRQ_RST;
    end else if (wr && at(I_WB_ADR, `PCG_IMSK_OFS)) begin
      imsk_ff <= merge(imsk_ff, I_WB_DAT, I_WB_SEL, `PCG_IRQ_WMASK);
    end
  end

  assign O_IRQ = |(ist_ff & imsk_ff);

  // ************************************************************
  // Read data.
  // ************************************************************

  // Captured with the request; unmapped reads return zero.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rdat_ff <= 32'h00000000;
    end else if (req) begin
      if (at(I_WB_ADR, `PCG_RUN_OFS)) begin
        rdat_ff <= run_gate_ff; // RL12
      end else if (at(I_WB_ADR, `PCG_SLP_OFS)) begin
        rdat_ff <= slp_gate_ff; // RL7
      end else if (at(I_WB_ADR, `PCG_DSL_OFS)) begin
        rdat_ff <= dsl_gate_ff;
      end else if (at(I_WB_ADR, `PCG_CFG_OFS)) begin
        rdat_ff <= cfg_ff;
      end else if (at(I_WB_ADR, `PCG_IST_OFS)) begin
        rdat_ff <= ist_ff;
      end else if (at(I_WB_ADR, `PCG_IMSK_OFS)) begin
        rdat_ff <= imsk_ff;
      end else begin
        rdat_ff <= 32'h00000000;
      end
    end
  end

  assign O_WB_DAT = rdat_ff;

  // ************************************************************
  // Assertions.
  // ************************************************************
  reserved_zero_a: assert property ( // RL12
    @(posedge I_MCLK) disable iff (I_RST)
    ((run_gate_ff | slp_gate_ff | dsl_gate_ff)
      & ~`PCG_GATE_WMASK) == 32'h00000000)
    else $error("Reserved gate bit is set.");

  reset_clear_a: assert property ( // RL3
    @(posedge I_MCLK) $fell(I_RST) |->
    (run_gate_ff == 32'h00000000 && slp_gate_ff == 32'h00000000
     && en_ff == 8'h00))
    else $error("Gate bits not zero after reset.");

  run_apply_a: assert property ( // RL5
    @(posedge I_MCLK) disable iff (I_RST)
    (pwr == pcg_pkg::PCG_RUN) |=> (en_ff == units_of($past(run_gate_ff))))
    else $error("Run settings not applied.");

  sleep_apply_a: assert property ( // RL6
    @(posedge I_MCLK) disable iff (I_RST)
    (pwr == pcg_pkg::PCG_SLEEP && auto_gate)
    |=> (en_ff == units_of($past(slp_gate_ff))))
    else $error("Sleep settings not applied under auto gating.");

  sleep_noacg_a: assert property ( // RL6
    @(posedge I_MCLK) disable iff (I_RST)
    (pwr == pcg_pkg::PCG_SLEEP && !auto_gate)
    |=> (en_ff == units_of($past(run_gate_ff))))
    else $error("Sleep settings used without auto gating.");

  sleep_write_a: assert property ( // RL7
    @(posedge I_MCLK) disable iff (I_RST)
    (wr && at(I_WB_ADR, `PCG_SLP_OFS) && I_WB_SEL == 4'hF)
    |=> (slp_gate_ff == ($past(I_WB_DAT) & `PCG_GATE_WMASK)) ##0 O_WB_ACK)
    else $error("Sleep gate write lost.");

  wb_answer_a: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    req |=> (O_WB_ACK != O_WB_ERR) ##1 (!O_WB_ACK && !O_WB_ERR))
    else $error("Bus answer missing or held too long.");

  fault_unit_a: assert property ( // RL2
    @(posedge I_MCLK) disable iff (I_RST)
    (I_PERIPH_REQ && I_PERIPH_SEL == 8'h01 && !en_ff[0])
    |=> O_PERIPH_FAULT)
    else $error("Async serial access while gated not faulted.");

  irq_level_a: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    (fault && imsk_ff[`PCG_EV_FAULT]) |=> O_IRQ)
    else $error("Unmasked fault did not raise the interrupt.");

endmodule : pcg_top
`default_nettype wire

/* rtl/pcg_params.svh */
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
// ************************************************************
// Register offsets, byte addresses within the block.
// ************************************************************
`define PCG_RUN_OFS   12'h104
`define PCG_SLP_OFS   12'h114
`define PCG_DSL_OFS   12'h124
`define PCG_CFG_OFS   12'h1E0
`define PCG_IST_OFS   12'h1F0
`define PCG_IMSK_OFS  12'h1F4
// ************************************************************
// Field positions and masks.
// ************************************************************
`define PCG_GPC3_BIT  19
`define PCG_GPC2_BIT  18
`define PCG_GPC1_BIT  17
`define PCG_GPC0_BIT  16
`define PCG_TWU0_BIT  12
`define PCG_SSU1_BIT  5
`define PCG_SSU0_BIT  4
`define PCG_ASU0_BIT  0
`define PCG_ACG_BIT   0
`define PCG_GATE_WMASK 32'h000F1031
`define PCG_CFG_WMASK  32'h00000001
`define PCG_IRQ_WMASK  32'h00000003
`define PCG_EV_FAULT  0
`define PCG_EV_PWR    1
// ************************************************************
// Reset values.
// ************************************************************
`define PCG_GATE_RST  32'h00000000
`define PCG_CFG_RST   32'h00000000
`define PCG_IRQ_RST   32'h00000000
`endif

/* rtl/pcg_pkg.sv */
// ************************************************************
// Shared types.
// ************************************************************
package pcg_pkg;
  // Power state presented by the power manager.
  typedef enum logic [1:0] {
    PCG_RUN,
    PCG_SLEEP,
    PCG_DEEP
  } pcg_pwr_t;
endpackage : pcg_pkg

/* rtl/pcg_clk_gate.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Glitch-free clock gate for one peripheral.
// ************************************************************
module pcg_clk_gate (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  output logic      o_gclk
);
  logic en_lo_ff; // Enable captured while the clock is low.

  // Outside reset the enable changes only on the falling edge, so the AND below
  // never cuts a high phase short.
  always_ff @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_lo_ff <= 1'b0;
    end else begin
      en_lo_ff <= i_en; // RL15
    end
  end

  // Gated clock: no clock at all while the enable is off.
  assign o_gclk = i_clk & en_lo_ff; // RL1

  // Sampled on the falling edge, so the high phase is what is seen.
  gclk_off_a: assert property ( // RL1
    @(negedge i_clk) disable iff (i_rst) !en_lo_ff |-> !o_gclk)
    else $error("Gated clock high while its gate is off.");
endmodule : pcg_clk_gate
`default_nettype wire

/* rtl/pcg_fault_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Peripheral access checker: faults accesses to unclocked units.
// ************************************************************
module pcg_fault_chk (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_req,
  input  wire logic [7:0] i_sel,
  input  wire logic [7:0] i_en,
  output logic            o_fault,
  output logic            o_grant
);
  logic hit_off; // Selected unit has its clock withheld.

  // A request with no unit selected is not ours and is ignored.
  assign hit_off = (|i_sel) && ((i_sel & i_en) == 8'h00);

  // One-cycle answer: fault instead of completion when gated off.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault <= 1'b0;
      o_grant <= 1'b0;
    end else begin
      o_fault <= i_req & hit_off; // RL2
      o_grant <= i_req & (|i_sel) & ~hit_off;
    end
  end

  fault_resp_a: assert property ( // RL2
    @(posedge i_clk) disable iff (i_rst)
    (i_req && hit_off) |=> (o_fault && !o_grant))
    else $error("Access to an unclocked unit not faulted.");
endmodule : pcg_fault_chk
`default_nettype wire

/* dv/pcg_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pcg_params.svh"
module pcg_top_tb;
  // ************************************************************
  // Stimulus, shadow copies and score counters.
  // ************************************************************
  logic        mclk;        // System clock, 8 ns period.
  logic        rst;         // Asynchronous reset, active high.
  logic        wb_cyc;      // Bus cycle.
  logic        wb_stb;      // Bus strobe.
  logic        wb_we;       // Bus direction.
  logic [11:0] wb_adr;      // Byte address inside the block.
  logic [3:0]  wb_sel;      // Byte lanes.
  logic [31:0] wb_dat;      // Write data.
  logic [1:0]  pwr;         // Power state presented to the block.
  logic        per_req;     // Peripheral access pulse.
  logic [7:0]  per_sel;     // One-hot unit of that access.
  logic [31:0] seed;        // Xorshift state, fixed start so runs repeat.
  logic [31:0] shd [0:2];   // Expected run, sleep and deep gate words.
  logic [31:0] rdv;         // Read data taken at the answer.
  logic        erv;         // Error answer taken with it.
  logic [7:0]  en_x;        // Expected effective enables.
  int          miscompares; // Mismatches seen.
  int          checks_done; // Comparisons made.
  wire  [31:0] wb_q;        // Read data from the block.
  wire         wb_ack;      // Normal answer.
  wire         wb_err;      // Error answer.
  wire         p_fault;     // Access refused.
  wire         p_grant;     // Access allowed.
  wire  [7:0]  p_en;        // Effective enables.
  wire  [7:0]  p_clk;       // Gated clocks.
  wire         irq;         // Level interrupt.

  pcg_top dut_u (.I_MCLK(mclk), .I_RST(rst), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb),
    .I_WB_WE(wb_we), .I_WB_ADR(wb_adr), .I_WB_SEL(wb_sel), .I_WB_DAT(wb_dat),
    .O_WB_DAT(wb_q), .O_WB_ACK(wb_ack), .O_WB_ERR(wb_err), .I_PWR_STATE(pwr),
    .I_PERIPH_REQ(per_req), .I_PERIPH_SEL(per_sel), .O_PERIPH_FAULT(p_fault),
    .O_PERIPH_GRANT(p_grant), .O_PERIPH_EN(p_en), .O_PERIPH_CLK(p_clk), .O_IRQ(irq));

  // The clock toggles every half period.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ************************************************************
  // Expectation helpers.
  // ************************************************************
  // Xorshift step; never reaches zero from a nonzero start.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Gate word to unit vector, counter3 in the top bit.
  function automatic logic [7:0] unit_map(input logic [31:0] r);
    return {r[19], r[18], r[17], r[16], r[12], r[5], r[4], r[0]};
  endfunction : unit_map

  // Run, sleep, deep gate register offsets by index.
  function automatic logic [11:0] gate_adr(input int idx);
    return (idx == 0) ? `PCG_RUN_OFS : (idx == 1) ? `PCG_SLP_OFS : `PCG_DSL_OFS;
  endfunction : gate_adr

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Bus and access drivers; entered just after a rising edge.
  // ************************************************************
  // One classic cycle held until ack or err, then one idle cycle.
  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= dat;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 64);
    rdv = wb_q;
    erv = wb_err;
    if (n >= 64) begin
      miscompares++;
      $display("[ERR] bus answer expected within 64 cycles seen none");
      tally_and_finish();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
  endtask : wb_cycle

  task automatic chk_reg(input string what, input logic [11:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 4'hF, 32'h00000000);
    chk_word(what, exp, rdv);
  endtask : chk_reg

  // Lane-merged write that keeps the shadow copy in step.
  task automatic gate_wr(input int idx, input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] lm;
    lm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wb_cycle(1'b1, gate_adr(idx), sel, dat);
    shd[idx] = ((shd[idx] & ~lm) | (dat & lm)) & `PCG_GATE_WMASK;
  endtask : gate_wr

  // One access pulse; the answer stands one cycle after it is taken.
  task automatic periph(input logic [7:0] sel, input logic exp_f, input logic exp_g);
    per_req <= 1'b1;
    per_sel <= sel;
    @(posedge mclk);
    per_req <= 1'b0;
    per_sel <= 8'h00;
    @(posedge mclk);
    chk_bit("fault", exp_f, p_fault);
    chk_bit("grant", exp_g, p_grant);
  endtask : periph

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    // Reset is set apart so that the idle bus word cannot pad it to zero.
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = 51'h0;
    {pwr, per_req, per_sel} = 11'h000;
    {miscompares, checks_done} = {32'd0, 32'd0};
    seed = 32'd37;
    for (int j = 0; j < 3; j++) shd[j] = 32'h00000000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Gate, config and mask registers and the enables start cleared.
    for (int j = 0; j < 3; j++) chk_reg("gate reset", gate_adr(j), 32'h00000000);
    chk_reg("cfg reset", `PCG_CFG_OFS, 32'h00000000);
    chk_reg("mask reset", `PCG_IMSK_OFS, 32'h00000000);
    chk_word("en reset", 32'h00000000, {24'h0, p_en});
    $display("test reset done");
    // Random and all-ones data with random lanes; reserved bits must stay zero.
    for (int k = 0; k < 15; k++) begin
      seed = xs(seed);
      gate_wr(k % 3, (k < 3) ? 4'hF : seed[3:0], (k < 3) ? 32'hFFFFFFFF : xs(seed));
      chk_reg("gate rw", gate_adr(k % 3), shd[k % 3]);
    end
    // Read-modify-write that hands back the reserved bits as read.
    chk_reg("rmw read", gate_adr(0), shd[0]);
    gate_wr(0, 4'hF, rdv | 32'h00000001);
    chk_reg("rmw keep", gate_adr(0), shd[0]);
    $display("test gate fields done");
    // Unmapped place: error answer, reads zero.
    wb_cycle(1'b1, 12'h200, 4'hF, 32'hFFFFFFFF);
    chk_bit("unmapped write err", 1'b1, erv);
    wb_cycle(1'b0, 12'h200, 4'hF, 32'h00000000);
    chk_bit("unmapped read err", 1'b1, erv);
    chk_word("unmapped read", 32'h00000000, rdv);
    $display("test unmapped done");
    // Each power state with auto gating off and on; gated clocks follow.
    gate_wr(0, 4'hF, 32'h000A1020);
    gate_wr(1, 4'hF, 32'h00050011);
    gate_wr(2, 4'hF, 32'h000C0030);
    for (int c = 0; c < 2; c++) begin
      wb_cycle(1'b1, `PCG_CFG_OFS, 4'hF, c);
      for (int s = 0; s < 4; s++) begin
        pwr <= s[1:0];
        repeat (4) @(posedge mclk);
        en_x = unit_map((c == 1 && s == 1) ? shd[1] : (c == 1 && s == 2) ? shd[2] : shd[0]);
        chk_word("enables", {24'h0, en_x}, {24'h0, p_en});
        #2;
        chk_word("clk high", {24'h0, en_x}, {24'h0, p_clk});
        @(negedge mclk);
        #2;
        chk_word("clk low", 32'h00000000, {24'h0, p_clk});
        @(posedge mclk);
      end
    end
    wb_cycle(1'b1, `PCG_CFG_OFS, 4'hF, 32'h00000000);
    pwr <= 2'd0;
    repeat (3) @(posedge mclk);
    $display("test power states done");
    // Every unit addressed: unclocked ones fault, clocked ones pass.
    en_x = unit_map(shd[0]);
    for (int u = 0; u < 8; u++) periph(8'h01 << u, ~en_x[u], en_x[u]);
    periph(8'h00, 1'b0, 1'b0);
    $display("test access done");
    // Interrupt: raised by a fault, masked, unmasked, cleared.
    wb_cycle(1'b1, `PCG_IST_OFS, 4'hF, 32'h00000003);
    chk_reg("status clear", `PCG_IST_OFS, 32'h00000000);
    periph(8'h01, 1'b1, 1'b0);
    chk_reg("status fault", `PCG_IST_OFS, 32'h00000001);
    chk_bit("irq masked", 1'b0, irq);
    wb_cycle(1'b1, `PCG_IMSK_OFS, 4'hF, 32'h00000001);
    chk_bit("irq raised", 1'b1, irq);
    wb_cycle(1'b1, `PCG_IST_OFS, 4'hF, 32'h00000001);
    chk_bit("irq cleared", 1'b0, irq);
    pwr <= 2'd1;
    repeat (3) @(posedge mclk);
    chk_reg("status power", `PCG_IST_OFS, 32'h00000002);
    wb_cycle(1'b1, `PCG_IMSK_OFS, 4'hF, 32'h00000003);
    chk_bit("irq power", 1'b1, irq);
    // A fault while its mask bit is set keeps the interrupt up.
    periph(8'h01, 1'b1, 1'b0);
    chk_bit("irq fault", 1'b1, irq);
    $display("test interrupt done");
    // Reset in mid-run drops every gate at once.
    pwr <= 2'd0;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk_word("en in reset", 32'h00000000, {24'h0, p_en});
    chk_word("clk in reset", 32'h00000000, {24'h0, p_clk});
    rst <= 1'b0;
    @(posedge mclk);
    chk_reg("run after reset", `PCG_RUN_OFS, 32'h00000000);
    chk_reg("sleep after reset", `PCG_SLP_OFS, 32'h00000000);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : pcg_top_tb
`default_nettype wire
